// ==== inc/mep_cfg.svh ====
`ifndef MEP_CFG_SVH
`define MEP_CFG_SVH
// Function
// [RULE1] Macro entry always targets writable page one.
// [RULE2] Low five bits select first 32 words.
// [RULE3] Bits five to seven pass through unused.
// [RULE4] Page select happens during primary decode.
// [RULE5] Macro acts only on decoder page zero.
// [RULE6] Macro keeps decoder selection; local branch changes.
// [RULE7] Fetch, buffer, register copy, class decode order.
// [RULE8] Secondary decode forms address from register fields.
// [RULE9] Two 16-bit registers: buffer and current.
// [RULE10] Counter points past macro on entry.
// [RULE11] Current holds macro; next word in flight.
// [RULE12] Constant registers hold zeros and ones.
// [RULE13] User refetches next word if needed.
// [RULE14] User advances counter and fetches before exit; the model fetches at next_word_ctr but never advances the counter.
// [RULE15] User copies buffer and returns to page zero.
// [RULE16] Restart state fetches at counter, then advance.
// [RULE17] Advance state increments counter, fetches, decodes.
// [RULE18] Decode state decodes buffer, copies to current.
// [RULE19] I/O branch enters any page, no decoder.
// [RULE20] I/O branch waits for idle memory traffic.
// [RULE21] User leaves writable store by page branch.
// [RULE22] User restores constant registers before leaving.
// [RULE23] Equal address store updates prefetched buffer.
`define MEP_W 16
`define MEP_AW 15
`define MEP_UAW 9
`define MEP_OPC_MASK 16'hFF00
`define MEP_OPC_VAL 16'h8A00
`define MEP_VEC_LSB 0
`define MEP_VEC_MSB 4
`define MEP_PAR_LSB 5
`define MEP_PAR_MSB 7
`define MEP_WCS_PAGE 2'h1
`define MEP_ROM_PAGE 2'h0
`define MEP_DEC_PAGE0 2'h0
`define MEP_ADDR_RESTART 9'h13E
`define MEP_ADDR_ADVANCE 9'h092
`define MEP_ADDR_DECODE 9'h02D
`define MEP_ZEROS 16'h0000
`define MEP_ONES 16'hFFFF
`define MEP_CLASS_LSB 12
`define MEP_CLASS_MSB 15
`define MEP_SEC_LSB 6
`define MEP_SEC_MSB 11
`endif

// ==== inc/mep_pkg.sv ====
package mep_pkg;
    typedef enum logic [2:0] {
        MEP_RUN, MEP_RESTART, MEP_ADVANCE, MEP_DECODE, MEP_IOWAIT
    } mep_state_t;
endpackage : mep_pkg

// ==== verilog/mep_core.sv ====
`timescale 1ns/1ps
`include "mep_cfg.svh"
module mep_core
    import mep_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [1:0] dec_page_sel_in,
    input wire logic local_page_branch,
    input wire logic [1:0] local_branch_page,
    input wire logic rom_restart_req,
    input wire logic fetch_start,
    input wire logic mem_word_valid,
    input wire logic [15:0] mem_word,
    input wire logic copy_req,
    input wire logic secondary_req,
    input wire logic store_valid,
    input wire logic [14:0] store_addr,
    input wire logic [15:0] store_data,
    input wire logic io_branch_req,
    input wire logic [1:0] io_branch_page,
    input wire logic [8:0] io_branch_addr,
    input wire logic dma_busy,
    input wire logic cpu_mem_busy,
    output logic [1:0] store_page,
    output logic [8:0] micro_addr,
    output logic [1:0] dec_page,
    output logic [15:0] instruction_buffer,
    output logic [15:0] current_instr,
    output logic [14:0] next_word_ctr,
    output logic fetch_req,
    output logic [14:0] fetch_addr,
    output logic [2:0] user_param,
    output logic [15:0] gr_zero_const,
    output logic [15:0] gr_ones_const,
    output logic equal_address_flag,
    output logic [3:0] class_sel,
    output logic [5:0] field_addr
);
    // =====================================================
    // State record.
    typedef struct packed {
        mep_state_t st;
        logic [1:0] page;
        logic [8:0] uaddr;
        logic [1:0] dec;
        logic [15:0] ibuf;
        logic [15:0] cir;
        logic [14:0] nwc;
        logic fetch;
        logic [14:0] faddr;
        logic [2:0] par;
        logic [15:0] rz;
        logic [15:0] ro;
        logic eqf;
        logic [3:0] cls;
        logic [5:0] fld;
    } mep_regs_t;

    mep_regs_t q_r;
    mep_regs_t q_nxt;
    logic [1:0] dps_s1_r;
    logic [1:0] dps_s2_r;
    logic dma_s1_r;
    logic dma_s2_r;
    logic cpu_s1_r;
    logic cpu_s2_r;
    logic is_macro;

    assign is_macro = ((q_r.ibuf & `MEP_OPC_MASK) == `MEP_OPC_VAL);

    // =====================================================
    // Synchronisers for outside levels.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dps_s1_r <= `MEP_DEC_PAGE0;
            dps_s2_r <= `MEP_DEC_PAGE0;
            dma_s1_r <= 1'b0;
            dma_s2_r <= 1'b0;
            cpu_s1_r <= 1'b0;
            cpu_s2_r <= 1'b0;
        end else begin
            dps_s1_r <= dec_page_sel_in;
            dps_s2_r <= dps_s1_r;
            dma_s1_r <= dma_busy;
            dma_s2_r <= dma_s1_r;
            cpu_s1_r <= cpu_mem_busy;
            cpu_s2_r <= cpu_s1_r;
        end
    end

    // =====================================================
    // Next state.
    always_comb begin
        q_nxt = q_r;
        q_nxt.fetch = 1'b0;
        q_nxt.eqf = 1'b0;
        if (mem_word_valid) begin
            q_nxt.ibuf = mem_word; // RULE7 RULE9
        end
        if (store_valid && store_addr == q_r.nwc) begin
            q_nxt.eqf = 1'b1; // RULE23
            q_nxt.ibuf = store_data; // RULE23
        end
        if (local_page_branch) begin
            q_nxt.dec = local_branch_page; // RULE6
        end else if (q_r.page == `MEP_ROM_PAGE) begin
            q_nxt.dec = dps_s2_r;
        end
        if (secondary_req) begin
            q_nxt.fld = q_r.cir[`MEP_SEC_MSB:`MEP_SEC_LSB]; // RULE8
        end
        if (fetch_start) begin
            q_nxt.fetch = 1'b1; // RULE7
            q_nxt.faddr = q_r.nwc;
        end
        case (q_r.st)
            MEP_RUN: begin
                if (io_branch_req) begin
                    q_nxt.st = MEP_IOWAIT; // RULE20
                end else if (rom_restart_req) begin
                    q_nxt.page = `MEP_ROM_PAGE;
                    q_nxt.uaddr = `MEP_ADDR_RESTART;
                    q_nxt.st = MEP_RESTART;
                end else if (copy_req) begin
                    q_nxt.st = MEP_DECODE;
                end
            end
            MEP_RESTART: begin
                q_nxt.fetch = 1'b1; // RULE16
                q_nxt.faddr = q_r.nwc; // RULE16
                q_nxt.uaddr = `MEP_ADDR_ADVANCE; // RULE16
                q_nxt.st = MEP_ADVANCE;
            end
            MEP_ADVANCE: begin
                q_nxt.nwc = q_r.nwc + 15'h0001; // RULE17
                q_nxt.fetch = 1'b1; // RULE17
                q_nxt.faddr = q_r.nwc + 15'h0001;
                q_nxt.uaddr = `MEP_ADDR_DECODE; // RULE17
                q_nxt.st = MEP_DECODE;
            end
            MEP_DECODE: begin
                q_nxt.cir = q_r.ibuf; // RULE18 RULE7 RULE9
                q_nxt.cls = q_r.ibuf[`MEP_CLASS_MSB:`MEP_CLASS_LSB];
                q_nxt.st = MEP_RUN;
                if (is_macro && q_r.dec == `MEP_DEC_PAGE0) begin // RULE5
                    q_nxt.page = `MEP_WCS_PAGE; // RULE1 RULE4
                    q_nxt.uaddr = {4'h0,
                        q_r.ibuf[`MEP_VEC_MSB:`MEP_VEC_LSB]}; // RULE2
                    q_nxt.par = q_r.ibuf[`MEP_PAR_MSB:`MEP_PAR_LSB]; // RULE3
                    q_nxt.nwc = q_r.nwc + 15'h0001; // RULE10
                    q_nxt.fetch = 1'b1; // RULE11
                    q_nxt.faddr = q_r.nwc + 15'h0001; // RULE11
                    q_nxt.rz = `MEP_ZEROS; // RULE12
                    q_nxt.ro = `MEP_ONES; // RULE12
                end else begin
                    q_nxt.page = `MEP_ROM_PAGE;
                    q_nxt.uaddr = {3'h0,
                        q_r.ibuf[`MEP_CLASS_MSB:`MEP_CLASS_LSB], 2'h0};
                end
            end
            MEP_IOWAIT: begin
                if (!dma_s2_r && !cpu_s2_r) begin // RULE20
                    q_nxt.page = io_branch_page; // RULE19
                    q_nxt.uaddr = io_branch_addr; // RULE19
                    q_nxt.st = MEP_RUN;
                end
            end
            default: begin
                q_nxt.st = MEP_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= '0;
            q_r.st <= MEP_RUN;
            q_r.rz <= `MEP_ZEROS;
            q_r.ro <= `MEP_ONES;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign store_page = q_r.page;
    assign micro_addr = q_r.uaddr;
    assign dec_page = q_r.dec;
    assign instruction_buffer = q_r.ibuf;
    assign current_instr = q_r.cir;
    assign next_word_ctr = q_r.nwc;
    assign fetch_req = q_r.fetch;
    assign fetch_addr = q_r.faddr;
    assign user_param = q_r.par;
    assign gr_zero_const = q_r.rz;
    assign gr_ones_const = q_r.ro;
    assign equal_address_flag = q_r.eqf;
    assign class_sel = q_r.cls;
    assign field_addr = q_r.fld;

    // =====================================================
    // Checks.
    sequence s_macro_decode;
        q_r.st == MEP_DECODE && is_macro && q_r.dec == `MEP_DEC_PAGE0;
    endsequence

    sequence s_other_decode;
        q_r.st == MEP_DECODE && is_macro && q_r.dec != `MEP_DEC_PAGE0;
    endsequence

    sequence s_restart_walk;
        fetch_req && micro_addr == `MEP_ADDR_ADVANCE
        ##1 fetch_req && micro_addr == `MEP_ADDR_DECODE
        ##1 q_r.st == MEP_RUN;
    endsequence

    sequence s_io_free;
        q_r.st == MEP_IOWAIT && !dma_s2_r && !cpu_s2_r;
    endsequence

    AST_MACRO_PAGE: assert property ( // RULE1
        @(posedge ref_clk) disable iff (!nrst)
        s_macro_decode |=> store_page == `MEP_WCS_PAGE)
        else $error("macro did not enter page one");
    AST_MACRO_VEC: assert property ( // RULE2
        @(posedge ref_clk) disable iff (!nrst)
        s_macro_decode |=> micro_addr ==
        9'($past(instruction_buffer[`MEP_VEC_MSB:`MEP_VEC_LSB])))
        else $error("macro vector out of range");
    AST_MACRO_PAR: assert property ( // RULE3
        @(posedge ref_clk) disable iff (!nrst)
        s_macro_decode |=> user_param ==
        $past(instruction_buffer[`MEP_PAR_MSB:`MEP_PAR_LSB]))
        else $error("parameter not kept");
    AST_MACRO_ONLY_P0: assert property ( // RULE5
        @(posedge ref_clk) disable iff (!nrst)
        s_other_decode |=> store_page == `MEP_ROM_PAGE)
        else $error("macro taken on other decoder page");
    AST_ENTRY_STATE: assert property ( // RULE10 RULE11
        @(posedge ref_clk) disable iff (!nrst)
        s_macro_decode |=> fetch_req
        && current_instr == $past(instruction_buffer)
        && next_word_ctr == $past(next_word_ctr) + 15'h0001
        && fetch_addr == next_word_ctr)
        else $error("entry pipeline state wrong");
    AST_MACRO_DEC_KEPT: assert property ( // RULE6
        @(posedge ref_clk) disable iff (!nrst)
        (s_macro_decode and !local_page_branch)
        |=> dec_page == $past(dec_page))
        else $error("macro changed decoder page");
    AST_LOCAL_BRANCH: assert property ( // RULE6
        @(posedge ref_clk) disable iff (!nrst)
        local_page_branch |=> dec_page == $past(local_branch_page))
        else $error("local page branch ignored");
    AST_CONSTS: assert property ( // RULE12
        @(posedge ref_clk) disable iff (!nrst)
        s_macro_decode |=> gr_zero_const == `MEP_ZEROS
        && gr_ones_const == `MEP_ONES)
        else $error("constant registers wrong");
    AST_RESTART_SEQ: assert property ( // RULE16
        @(posedge ref_clk) disable iff (!nrst)
        q_r.st == MEP_RESTART |=> s_restart_walk)
        else $error("restart sequence wrong");
    AST_RESTART_ADDR: assert property ( // RULE16
        @(posedge ref_clk) disable iff (!nrst)
        q_r.st == MEP_RESTART |=> fetch_addr == $past(next_word_ctr))
        else $error("restart fetch address wrong");
    AST_ADVANCE: assert property ( // RULE17
        @(posedge ref_clk) disable iff (!nrst)
        q_r.st == MEP_ADVANCE |=> micro_addr == `MEP_ADDR_DECODE
        && next_word_ctr == $past(next_word_ctr) + 15'h0001)
        else $error("advance state wrong");
    AST_DECODE_COPY: assert property ( // RULE18
        @(posedge ref_clk) disable iff (!nrst)
        q_r.st == MEP_DECODE |=> current_instr == $past(instruction_buffer))
        else $error("decode did not copy buffer");
    AST_CLASS_SEL: assert property ( // RULE7
        @(posedge ref_clk) disable iff (!nrst)
        q_r.st == MEP_DECODE |=> class_sel ==
        $past(instruction_buffer[`MEP_CLASS_MSB:`MEP_CLASS_LSB]))
        else $error("class selection wrong");
    AST_FETCH_PULSE: assert property ( // RULE7
        @(posedge ref_clk) disable iff (!nrst)
        fetch_start |=> fetch_req)
        else $error("fetch start not answered");
    AST_SECONDARY: assert property ( // RULE8
        @(posedge ref_clk) disable iff (!nrst)
        secondary_req |=> field_addr ==
        $past(current_instr[`MEP_SEC_MSB:`MEP_SEC_LSB]))
        else $error("field address wrong");
    AST_IO_IDLE: assert property ( // RULE20
        @(posedge ref_clk) disable iff (!nrst)
        (q_r.st == MEP_IOWAIT && (dma_s2_r || cpu_s2_r))
        |=> q_r.st == MEP_IOWAIT)
        else $error("io branch during memory traffic");
    AST_IO_TARGET: assert property ( // RULE19
        @(posedge ref_clk) disable iff (!nrst)
        s_io_free |=> store_page == $past(io_branch_page)
        && micro_addr == $past(io_branch_addr)
        && dec_page == $past(dec_page))
        else $error("io branch target wrong");
    AST_EQ_ADDR: assert property ( // RULE23
        @(posedge ref_clk) disable iff (!nrst)
        (store_valid && store_addr == next_word_ctr) |=> equal_address_flag
        && instruction_buffer == $past(store_data))
        else $error("equal address update missed");
    AST_MEM_LOAD: assert property ( // RULE9
        @(posedge ref_clk) disable iff (!nrst)
        (mem_word_valid && !(store_valid && store_addr == next_word_ctr))
        |=> instruction_buffer == $past(mem_word))
        else $error("buffer not loaded from memory");
endmodule : mep_core

// ==== verification/mep_wcs_model.sv ====
`timescale 1ns/1ps
// ==========================================================================
// User microprogram in the writable store: exits back to the read-only page.
module mep_wcs_model
    import mep_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [1:0] store_page,
    input wire logic slow,
    output logic fetch_start,
    output logic copy_req
);
    typedef struct packed {
        logic [3:0] wait_cnt;
        logic fetch;
        logic copy;
    } mep_wcs_st_t;
    mep_wcs_st_t state_r;
    mep_wcs_st_t state_nxt;
    logic [3:0] lim;

    assign lim = slow ? 4'h8 : 4'h2;
    assign fetch_start = state_r.fetch;
    assign copy_req = state_r.copy;

    // Constant registers are never written here, so they stay restored.
    always_comb begin
        state_nxt = state_r;
        state_nxt.fetch = 1'b0;
        state_nxt.copy = 1'b0;
        if (store_page != 2'h1 || state_r.copy) begin
            state_nxt.wait_cnt = 4'h0;
        end else begin
            state_nxt.wait_cnt = state_r.wait_cnt + 4'h1;
            state_nxt.fetch = (state_r.wait_cnt == lim);
            state_nxt.copy = (state_r.wait_cnt == lim + 4'h1);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule : mep_wcs_model

// ==== verification/tb_mep_core.sv ====
`timescale 1ns/1ps
module tb_mep_core;
    import mep_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] dec_page_sel_in = 2'h0, local_branch_page = 2'h0;
    logic [1:0] io_branch_page = 2'h0;
    logic local_page_branch = 1'b0, rom_restart_req = 1'b0, slow = 1'b0;
    logic fetch_tb = 1'b0, copy_tb = 1'b0, mem_word_valid = 1'b0;
    logic secondary_req = 1'b0, store_valid = 1'b0, io_branch_req = 1'b0;
    logic dma_busy = 1'b0, cpu_mem_busy = 1'b0;
    logic [15:0] mem_word = 16'h0000, store_data = 16'h0000;
    logic [14:0] store_addr = 15'h0000, nwc0;
    logic [8:0] io_branch_addr = 9'h000;
    wire fetch_u, copy_u, fetch_req, equal_address_flag;
    wire [1:0] store_page, dec_page;
    wire [8:0] micro_addr;
    wire [15:0] instruction_buffer, current_instr, gr_zero_const, gr_ones_const;
    wire [14:0] next_word_ctr, fetch_addr;
    wire [2:0] user_param;
    wire [3:0] class_sel;
    wire [5:0] field_addr;
    int num_errors = 0;
    int compares = 0;

    always #25 ref_clk = ~ref_clk;

    mep_core mep_core_i (.ref_clk(ref_clk), .nrst(nrst),
        .dec_page_sel_in(dec_page_sel_in), .local_page_branch(local_page_branch),
        .local_branch_page(local_branch_page), .rom_restart_req(rom_restart_req),
        .fetch_start(fetch_tb | fetch_u), .mem_word_valid(mem_word_valid),
        .mem_word(mem_word), .copy_req(copy_tb | copy_u),
        .secondary_req(secondary_req), .store_valid(store_valid),
        .store_addr(store_addr), .store_data(store_data),
        .io_branch_req(io_branch_req), .io_branch_page(io_branch_page),
        .io_branch_addr(io_branch_addr), .dma_busy(dma_busy),
        .cpu_mem_busy(cpu_mem_busy), .store_page(store_page),
        .micro_addr(micro_addr), .dec_page(dec_page),
        .instruction_buffer(instruction_buffer), .current_instr(current_instr),
        .next_word_ctr(next_word_ctr), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .user_param(user_param),
        .gr_zero_const(gr_zero_const), .gr_ones_const(gr_ones_const),
        .equal_address_flag(equal_address_flag), .class_sel(class_sel),
        .field_addr(field_addr));

    mep_wcs_model mep_wcs_model_i (.ref_clk(ref_clk), .nrst(nrst),
        .store_page(store_page), .slow(slow), .fetch_start(fetch_u),
        .copy_req(copy_u));

    // ======================================================================
    // Shared helpers.
    task automatic summarize;
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic load_word(input logic [15:0] w);
        @(posedge ref_clk);
        mem_word_valid <= 1'b1;
        mem_word <= w;
        @(posedge ref_clk);
        mem_word_valid <= 1'b0;
    endtask : load_word

    task automatic pulse_copy;
        @(posedge ref_clk);
        copy_tb <= 1'b1;
        @(posedge ref_clk);
        copy_tb <= 1'b0;
    endtask : pulse_copy

    task automatic wait_page(input logic [1:0] p);
        int n;
        n = 0;
        while (store_page !== p && n < 40) begin
            cyc(1);
            n++;
        end
        chk(store_page === p, "page wait timed out");
    endtask : wait_page

    // ======================================================================
    // Scenarios.
    task automatic test_macro(input logic [4:0] v, input logic [2:0] p,
                              input logic loc);
        logic [15:0] w;
        w = {8'h8A, p, v};
        nwc0 = next_word_ctr;
        load_word(w);
        pulse_copy();
        cyc(1);
        chk(store_page === 2'h1, "macro missed page one");
        chk(micro_addr === {4'h0, v}, "macro vector wrong");
        chk(user_param === p, "macro parameter wrong");
        chk(fetch_req === 1'b1, "no fetch in decode");
        chk(current_instr === w, "macro not current");
        chk(next_word_ctr === nwc0 + 15'h1, "counter not advanced");
        chk(dec_page === 2'h0, "decoder page changed");
        if (loc) begin
            @(posedge ref_clk);
            local_page_branch <= 1'b1;
            local_branch_page <= 2'h1;
            @(posedge ref_clk);
            local_page_branch <= 1'b0;
            cyc(1);
            chk(dec_page === 2'h1, "local branch ignored");
        end
        load_word(16'h1234);
        wait_page(2'h0);
        chk(current_instr === 16'h1234, "next word not copied");
        chk(class_sel === 4'h1, "class wrong");
        chk(micro_addr === 9'h004, "class address wrong");
    endtask : test_macro

    task automatic test_other_decoder;
        @(posedge ref_clk);
        dec_page_sel_in <= 2'h1;
        cyc(4);
        load_word(16'h8A05);
        pulse_copy();
        cyc(3);
        chk(store_page === 2'h0, "macro on other decoder");
        chk(micro_addr === 9'h020, "other set decode wrong");
        @(posedge ref_clk);
        dec_page_sel_in <= 2'h0;
        cyc(4);
    endtask : test_other_decoder

    task automatic test_restart;
        load_word(16'h5A3C);
        nwc0 = next_word_ctr;
        @(posedge ref_clk);
        rom_restart_req <= 1'b1;
        @(posedge ref_clk);
        rom_restart_req <= 1'b0;
        #1;
        chk(micro_addr === 9'h13E, "restart state");
        cyc(1);
        chk(fetch_req === 1'b1 && fetch_addr === nwc0, "restart fetch");
        chk(micro_addr === 9'h092, "advance state");
        cyc(1);
        chk(fetch_req === 1'b1 && micro_addr === 9'h02D, "advance");
        chk(next_word_ctr === nwc0 + 15'h1, "advance count");
        cyc(1);
        chk(current_instr === 16'h5A3C && class_sel === 4'h5, "decode");
        @(posedge ref_clk);
        secondary_req <= 1'b1;
        @(posedge ref_clk);
        secondary_req <= 1'b0;
        #1;
        chk(field_addr === 6'h28, "field address");
    endtask : test_restart

    task automatic test_store;
        @(posedge ref_clk);
        store_valid <= 1'b1;
        store_addr <= next_word_ctr;
        store_data <= 16'hC3A5;
        @(posedge ref_clk);
        store_valid <= 1'b0;
        #1;
        chk(equal_address_flag === 1'b1, "no equal flag");
        chk(instruction_buffer === 16'hC3A5, "buffer not updated");
    endtask : test_store

    task automatic test_io;
        @(posedge ref_clk);
        io_branch_page <= 2'h2;
        io_branch_addr <= 9'h055;
        dma_busy <= 1'b1;
        repeat (3) @(posedge ref_clk);
        io_branch_req <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            dma_busy <= (i == 0);
            cpu_mem_busy <= (i == 1);
            repeat (6) @(posedge ref_clk);
            chk(store_page === 2'h0, "branch during memory traffic");
        end
        cpu_mem_busy <= 1'b0;
        wait_page(2'h2);
        io_branch_req <= 1'b0;
        chk(micro_addr === 9'h055 && dec_page === 2'h0, "io target");
    endtask : test_io

    // ======================================================================
    // Main sequence and watchdog.
    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        cyc(1);
        chk(gr_zero_const === 16'h0000, "zeros constant");
        chk(gr_ones_const === 16'hFFFF, "ones constant");
        test_macro(5'h1F, 3'h7, 1'b0);
        test_macro(5'h00, 3'h0, 1'b0);
        slow <= 1'b1;
        test_macro(5'h0A, 3'h5, 1'b1);
        test_other_decoder();
        test_restart();
        test_store();
        test_io();
        summarize();
    end

    initial begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        summarize();
    end
endmodule : tb_mep_core
